//--- src/seb_pkg.sv
// constants and carrier types of the serial byte memory bus slave
// assumes a 250 MHz core clock and a far master that makes the bus clock
package seb_pkg;

    // ********************************************************
    // sizes
    // ********************************************************
    localparam int          DATA_W     = 8;
    localparam int          BLK_W      = 3;
    localparam int          TYPE_W     = 4;
    localparam int          ADDR_W     = 11;
    localparam int          MEM_BYTES  = 2048;
    localparam int          FIFO_DEPTH = 16;
    localparam int          TIMER_W    = 22;
    localparam logic [3:0]  BYTE_BITS  = 4'h8;

    // ********************************************************
    // field positions
    // ********************************************************
    localparam int          SA_TYPE_LSB = 4;
    localparam int          SA_BLK_LSB  = 1;
    localparam int          SA_RW_BIT   = 0;
    localparam int          PAGE_LSB    = 4;

    // ********************************************************
    // timing
    // ********************************************************
    localparam int          WR_TIME_MS    = 10;
    localparam int          CLK_PERIOD_NS = 4;
    localparam int          WR_CYCLES_DEF =
        (WR_TIME_MS * 1000000) / CLK_PERIOD_NS;

    // ********************************************************
    // types
    // ********************************************************
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_DEV  = 8'h02,
        ST_WORD = 8'h04,
        ST_DATA = 8'h08,
        ST_ACK  = 8'h10,
        ST_TX   = 8'h20,
        ST_MACK = 8'h40,
        ST_WAIT = 8'h80
    } seb_state_t;

    typedef struct packed {
        logic                scl1;
        logic                scl2;
        logic                scl3;
        logic                sda1;
        logic                sda2;
        logic                sda3;
        seb_state_t          st;
        seb_state_t          ackNext;
        logic [3:0]          bitCnt;
        logic [DATA_W-1:0]   shift;
        logic [ADDR_W-1:0]   addr;
        logic [ADDR_W-1:0]   wrPtr;
        logic                rdMode;
        logic                busy;
        logic [TIMER_W-1:0]  timer;
        logic                oe;
        logic                outLow;
    } seb_core_t;

endpackage

//--- src/seb_fifo.sv
// page write buffer fifo with valid and ready on both sides
// assumes one clock and a synchronous active high reset
`timescale 1ns/10ps
module seb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             flush,
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    output logic                  outValid,
    output logic [WIDTH-1:0]      outData,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wp;
        logic [AW:0]                 rp;
    } seb_fifo_st_t;

    seb_fifo_st_t cur;
    seb_fifo_st_t nxt_cur;

    // ********************************************************
    // flags
    // ********************************************************
    // extra pointer bit tells full from empty
    assign outValid = cur.wp != cur.rp;
    assign inReady  = !((cur.wp[AW] != cur.rp[AW]) &&
                        (cur.wp[AW-1:0] == cur.rp[AW-1:0]));
    assign outData  = cur.mem[cur.rp[AW-1:0]];

    // ********************************************************
    // next state
    // ********************************************************
    always_comb begin
        nxt_cur = cur;
        if (inValid && inReady) begin
            nxt_cur.mem[cur.wp[AW-1:0]] = inData;
            nxt_cur.wp = cur.wp + (AW+1)'(1);
        end
        if (outValid && outReady) begin
            nxt_cur.rp = cur.rp + (AW+1)'(1);
        end
        if (flush) begin
            nxt_cur.wp = '0;
            nxt_cur.rp = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= nxt_cur;
        end
    end

endmodule

//--- src/seb_slave.sv
// two-wire bus slave front end of a 16 Kbit byte memory
// assumes an external pull-up on sda and a master driving scl
`timescale 1ns/10ps
module seb_slave
    import seb_pkg::*;
#(
    parameter int          WR_CYCLES = WR_CYCLES_DEF,
    // arbitrary type code
    parameter logic [3:0]  DEV_TYPE  = 4'h5
) (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic scl,
    input  wire logic sdaIn,
    output logic      sdaOut,
    output logic      sdaOe,
    output logic      writeBusy
);

    seb_core_t          cur;
    seb_core_t          nxt_cur;
    logic [DATA_W-1:0]  memArr [0:MEM_BYTES-1];
    logic [DATA_W-1:0]  memRd;
    logic               sclRise;
    logic               sclFall;
    logic               startEv;
    logic               stopEv;
    logic               byteDone;
    logic               typeOk;
    logic               fifoPush;
    logic               fifoFlush;
    logic               fifoInReady;
    logic               fifoOutValid;
    logic [DATA_W-1:0]  fifoOutData;
    logic               memWe;

    // ********************************************************
    // pin events
    // ********************************************************
    // edges only from the second and third stages
    assign sclRise  = cur.scl2 && !cur.scl3;
    assign sclFall  = !cur.scl2 && cur.scl3;
    assign startEv  = cur.scl2 && cur.scl3 &&
                      cur.sda3 && !cur.sda2;
    assign stopEv   = cur.scl2 && cur.scl3 &&
                      !cur.sda3 && cur.sda2;
    assign byteDone = sclFall && (cur.bitCnt == BYTE_BITS);
    assign typeOk   = cur.shift[DATA_W-1:SA_TYPE_LSB] ==
                      DEV_TYPE;
    assign memRd    = memArr[cur.addr];
    assign memWe    = cur.busy && fifoOutValid;

    assign sdaOut    = cur.outLow;
    assign sdaOe     = cur.oe;
    assign writeBusy = cur.busy;

    // ********************************************************
    // page buffer
    // ********************************************************
    // full buffer makes the data byte go unanswered
    seb_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk      (core_clk),
        .rst      (sys_rst),
        .flush    (fifoFlush),
        .inValid  (fifoPush),
        .inData   (cur.shift),
        .inReady  (fifoInReady),
        .outValid (fifoOutValid),
        .outData  (fifoOutData),
        .outReady (cur.busy)
    );

    // ********************************************************
    // byte array
    // ********************************************************
    always_ff @(posedge core_clk) begin
        if (memWe) begin
            memArr[cur.wrPtr] <= fifoOutData;
        end
    end

    // ********************************************************
    // next state
    // ********************************************************
    always_comb begin
        nxt_cur   = cur;
        fifoPush  = 1'b0;
        fifoFlush = 1'b0;
        nxt_cur.outLow = 1'b0;
        nxt_cur.scl1 = scl;
        nxt_cur.scl2 = cur.scl1;
        nxt_cur.scl3 = cur.scl2;
        nxt_cur.sda1 = sdaIn;
        nxt_cur.sda2 = cur.sda1;
        nxt_cur.sda3 = cur.sda2;

        // self-timed write cycle, drains the buffer
        if (cur.busy) begin
            if (cur.timer == '0) begin
                nxt_cur.busy = 1'b0;
            end else begin
                nxt_cur.timer = cur.timer - TIMER_W'(1);
            end
        end
        if (memWe) begin
            // wrap inside the page
            nxt_cur.wrPtr[PAGE_LSB-1:0] =
                cur.wrPtr[PAGE_LSB-1:0] + 4'h1;
        end

        if (startEv) begin
            nxt_cur.st     = ST_DEV;
            nxt_cur.bitCnt = '0;
            nxt_cur.oe     = 1'b0;
            // committed bytes must survive a new start
            fifoFlush = !cur.busy;
        end else if (stopEv) begin
            nxt_cur.st = ST_IDLE;
            nxt_cur.oe = 1'b0;
            if (fifoOutValid && !cur.busy && !cur.rdMode) begin
                nxt_cur.busy  = 1'b1;
                nxt_cur.timer = TIMER_W'(WR_CYCLES - 1);
            end
        end else begin
            unique case (cur.st)
                ST_IDLE, ST_WAIT: begin
                    nxt_cur.oe = 1'b0;
                end
                ST_DEV, ST_WORD, ST_DATA: begin
                    if (sclRise) begin
                        nxt_cur.shift =
                            {cur.shift[DATA_W-2:0], cur.sda2};
                        nxt_cur.bitCnt = cur.bitCnt + 4'h1;
                    end
                    if (byteDone) begin
                        nxt_cur.bitCnt = '0;
                        nxt_cur.st     = ST_ACK;
                        nxt_cur.oe     = 1'b1;
                        if (cur.st == ST_DEV) begin
                            nxt_cur.rdMode =
                                cur.shift[SA_RW_BIT];
                            nxt_cur.addr[ADDR_W-1:DATA_W] =
                                cur.shift[SA_BLK_LSB+:BLK_W];
                            nxt_cur.ackNext =
                                cur.shift[SA_RW_BIT] ?
                                ST_TX : ST_WORD;
                            if (!typeOk || cur.busy) begin
                                nxt_cur.st = ST_IDLE;
                                nxt_cur.oe = 1'b0;
                            end
                        end else if (cur.st == ST_WORD) begin
                            nxt_cur.addr[DATA_W-1:0] =
                                cur.shift;
                            nxt_cur.wrPtr =
                                {cur.addr[ADDR_W-1:DATA_W],
                                 cur.shift};
                            nxt_cur.ackNext = ST_DATA;
                        end else if (fifoInReady && !cur.busy) begin
                            fifoPush = 1'b1;
                            nxt_cur.addr[PAGE_LSB-1:0] =
                                cur.addr[PAGE_LSB-1:0] +
                                4'h1;
                            nxt_cur.ackNext = ST_DATA;
                        end else begin
                            nxt_cur.st = ST_WAIT;
                            nxt_cur.oe = 1'b0;
                        end
                    end
                end
                ST_ACK: begin
                    if (sclFall) begin
                        nxt_cur.oe     = 1'b0;
                        nxt_cur.bitCnt = '0;
                        nxt_cur.st     = cur.ackNext;
                        if (cur.ackNext == ST_TX) begin
                            nxt_cur.shift = memRd;
                            nxt_cur.oe = !memRd[DATA_W-1];
                            nxt_cur.addr = cur.addr +
                                           ADDR_W'(1);
                        end
                    end
                end
                ST_TX: begin
                    if (sclRise) begin
                        nxt_cur.bitCnt = cur.bitCnt + 4'h1;
                    end
                    if (sclFall) begin
                        if (cur.bitCnt == BYTE_BITS) begin
                            nxt_cur.oe = 1'b0;
                            nxt_cur.st = ST_MACK;
                        end else begin
                            nxt_cur.shift =
                                {cur.shift[DATA_W-2:0], 1'b0};
                            nxt_cur.oe =
                                !cur.shift[DATA_W-2];
                        end
                    end
                end
                ST_MACK: begin
                    if (sclRise) begin
                        if (cur.sda2) begin
                            nxt_cur.st = ST_WAIT;
                        end else begin
                            nxt_cur.st      = ST_ACK;
                            nxt_cur.ackNext = ST_TX;
                        end
                    end
                end
                default: begin
                    nxt_cur.st = ST_IDLE;
                    nxt_cur.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cur      <= '0;
            cur.st   <= ST_IDLE;
            cur.ackNext <= ST_IDLE;
            cur.scl1 <= 1'b1;
            cur.scl2 <= 1'b1;
            cur.scl3 <= 1'b1;
            cur.sda1 <= 1'b1;
            cur.sda2 <= 1'b1;
            cur.sda3 <= 1'b1;
        end else begin
            cur <= nxt_cur;
        end
    end

    // ********************************************************
    // checks
    // ********************************************************
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    logic devHit;
    assign devHit = byteDone && (cur.st == ST_DEV) &&
                    typeOk && !cur.busy && !startEv && !stopEv;

    property p_low_only;
        sdaOe |-> !sdaOut;
    endproperty
    a_low_only: assert property (p_low_only)
        else $error("sda driven high");

    property p_busy_silent;
        writeBusy |-> !sdaOe;
    endproperty
    a_busy_silent: assert property (p_busy_silent)
        else $error("sda driven during write cycle");

    property p_write_start;
        stopEv && fifoOutValid && !cur.busy && !cur.rdMode
        |=> writeBusy[*8];
    endproperty
    a_write_start: assert property (p_write_start)
        else $error("write cycle not started by stop");

    property p_type_miss;
        byteDone && (cur.st == ST_DEV) && !typeOk &&
        !startEv && !stopEv
        |=> (cur.st == ST_IDLE) && !sdaOe;
    endproperty
    a_type_miss: assert property (p_type_miss)
        else $error("foreign type code answered");

    property p_dev_ack;
        devHit |=> (cur.st == ST_ACK) && sdaOe &&
            (cur.rdMode == $past(cur.shift[SA_RW_BIT]));
    endproperty
    a_dev_ack: assert property (p_dev_ack)
        else $error("address byte not acknowledged");

    property p_block_sel;
        devHit |=> cur.addr[ADDR_W-1:DATA_W] ==
            $past(cur.shift[SA_BLK_LSB+:BLK_W]);
    endproperty
    a_block_sel: assert property (p_block_sel)
        else $error("block select not taken");

    property p_word_addr;
        byteDone && (cur.st == ST_WORD) &&
        !startEv && !stopEv
        |=> (cur.addr[DATA_W-1:0] == $past(cur.shift)) &&
            (cur.wrPtr[DATA_W-1:0] == $past(cur.shift));
    endproperty
    a_word_addr: assert property (p_word_addr)
        else $error("array address not taken");

    property p_page_wrap;
        memWe |=> cur.wrPtr[ADDR_W-1:PAGE_LSB] ==
            $past(cur.wrPtr[ADDR_W-1:PAGE_LSB]);
    endproperty
    a_page_wrap: assert property (p_page_wrap)
        else $error("page write left its page");

    property p_tx_release;
        (cur.st == ST_TX) && byteDone && !startEv && !stopEv
        |=> !sdaOe && (cur.st == ST_MACK);
    endproperty
    a_tx_release: assert property (p_tx_release)
        else $error("line held after read byte");

    property p_read_nack;
        (cur.st == ST_MACK) && sclRise && cur.sda2 &&
        !startEv && !stopEv
        |=> (cur.st == ST_WAIT) ##1 !sdaOe;
    endproperty
    a_read_nack: assert property (p_read_nack)
        else $error("send continued after no ack");

    property p_clock_low;
        $changed(sdaOe) |-> !cur.scl2 ||
            $past(startEv) || $past(stopEv);
    endproperty
    a_clock_low: assert property (p_clock_low)
        else $error("sda moved with clock high");

    property p_start_seen;
        startEv |=> (cur.st == ST_DEV) && (cur.bitCnt == '0);
    endproperty
    a_start_seen: assert property (p_start_seen)
        else $error("start not seen");

    c_read_ack: cover property (devHit && cur.shift[SA_RW_BIT]);
    c_write_cyc: cover property ($rose(writeBusy));
    c_read_nack: cover property ((cur.st == ST_MACK) ##1
                                 (cur.st == ST_WAIT));
    c_buf_full: cover property (!fifoInReady);

endmodule

//--- verification/seb_master_model.sv
// two-wire bus master model for the byte memory bus slave
// assumes a resolved sda wire with pull-up; scl idles high between frames
`timescale 1ns/10ps
module seb_master_model (
    input  wire logic core_clk,
    input  wire logic sda,
    output logic      scl,
    output logic      mSdaOe
);
    // ********************************************************
    // idle bus
    // ********************************************************
    initial begin
        scl    = 1'b1;
        mSdaOe = 1'b0;
    end

    // ********************************************************
    // bus phases
    // ********************************************************
    // quarter of a 64 ns bus bit, changes land at falling core edges
    task automatic q();
        repeat (4) @(negedge core_clk);
    endtask

    // sda only pulled low or released, moved while scl is low
    task automatic clkBit(input logic drvLow, output logic seen);
        mSdaOe = drvLow;
        q();
        scl = 1'b1;
        q();
        seen = sda;
        q();
        scl = 1'b0;
        q();
    endtask

    // also serves as repeated start
    task automatic startBus();
        mSdaOe = 1'b0;
        q();
        scl = 1'b1;
        q();
        mSdaOe = 1'b1;
        q();
        scl = 1'b0;
        q();
    endtask

    // scl left high so the clock stands still after the frame
    task automatic stopBus();
        mSdaOe = 1'b1;
        q();
        scl = 1'b1;
        q();
        mSdaOe = 1'b0;
        q();
    endtask

    // msb first, then release for the slave's acknowledge
    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clkBit(!b[i], s);
        end
        clkBit(1'b0, s);
        ack = !s;
    endtask

    // master is the receiver on reads and acks unless ending
    task automatic recvByte(input logic ackIt, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clkBit(1'b0, b[i]);
        end
        clkBit(ackIt, s);
    endtask
endmodule

//--- verification/testbench.sv
// self-checking bench for the byte memory bus slave
// assumes seb_pkg, seb_slave and the master model are compiled first
`timescale 1ns/10ps
module testbench;
    import seb_pkg::*;
    // short write cycle so the run stays brief
    localparam int WR_N = 200;
    logic        core_clk;
    logic        sys_rst;
    logic        scl;
    logic        mSdaOe;
    logic        sdaWire;
    logic        sdaOut;
    logic        sdaOe;
    logic        writeBusy;
    logic        ack;
    logic [7:0]  rd;
    logic [7:0]  expMem [0:2047];
    logic [15:0] busyRun;
    logic [15:0] lastRun;
    int          badCount;
    int          samplesChecked;

    // ********************************************************
    // wiring
    // ********************************************************
    // open drain: the value driven counts, pull-up wins when released
    assign sdaWire = (sdaOe ? sdaOut : 1'b1) && !mSdaOe;
    seb_slave #(.WR_CYCLES(WR_N), .DEV_TYPE(4'h5)) dut (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .scl       (scl),
        .sdaIn     (sdaWire),
        .sdaOut    (sdaOut),
        .sdaOe     (sdaOe),
        .writeBusy (writeBusy)
    );
    seb_master_model m (
        .core_clk (core_clk),
        .sda      (sdaWire),
        .scl      (scl),
        .mSdaOe   (mSdaOe)
    );

    // length of the last busy run, in core cycles
    always @(negedge core_clk) begin
        busyRun <= (writeBusy === 1'b1) ? busyRun + 16'h1 : 16'h0;
        if (writeBusy !== 1'b1 && busyRun != 16'h0) begin
            lastRun <= busyRun;
        end
    end

    // ********************************************************
    // shared tasks
    // ********************************************************
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            badCount++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic openDev(input logic [2:0] blk, input logic rw,
                           input logic expAck);
        m.startBus();
        m.sendByte({4'h5, blk, rw}, ack);
        check("address ack", ack, expAck);
    endtask

    task automatic writeSeq(input logic [2:0] blk, input logic [7:0] arr,
                            input int n, input logic [7:0] base);
        logic [7:0] d;
        openDev(blk, 1'b0, 1'b1);
        m.sendByte(arr, ack);
        check("array ack", ack, 1'b1);
        for (int i = 0; i < n; i++) begin
            d = base + 8'(i);
            m.sendByte(d, ack);
            check("data ack", ack, i < 16);
            if (i < 16) begin
                expMem[{blk, arr[7:4], arr[3:0] + 4'(i)}] = d;
            end
        end
        m.stopBus();
        check("busy after stop", writeBusy, 1'b1);
    endtask

    task automatic waitIdle();
        int n;
        n = 0;
        while (writeBusy === 1'b1 && n < 1000) begin
            @(negedge core_clk);
            n++;
        end
        @(negedge core_clk);
        check("busy length ok", lastRun >= WR_N && lastRun <= WR_N + 1,
              1'b1);
    endtask

    // random read: set address by a write header, then read
    task automatic readSeq(input logic [2:0] blk, input logic [7:0] arr,
                           input int n);
        logic [10:0] a;
        openDev(blk, 1'b0, 1'b1);
        m.sendByte(arr, ack);
        check("array ack", ack, 1'b1);
        openDev(blk, 1'b1, 1'b1);
        for (int i = 0; i < n; i++) begin
            a = {blk, arr} + 11'(i);
            m.recvByte(i < n - 1, rd);
            check("read byte", rd, expMem[a]);
        end
        m.q();
        check("released after nack", sdaOe, 1'b0);
        m.stopBus();
    endtask

    // ********************************************************
    // scenarios
    // ********************************************************
    task automatic testReset();
        check("oe after reset", sdaOe, 1'b0);
        check("busy after reset", writeBusy, 1'b0);
        check("drive value", sdaOut, 1'b0);
        $display("test reset done");
    endtask

    // foreign type: no ack, later bytes ignored too
    task automatic testBadType();
        m.startBus();
        m.sendByte({4'h3, 3'h0, 1'b0}, ack);
        check("foreign type ack", ack, 1'b0);
        m.sendByte(8'h00, ack);
        check("ignored byte ack", ack, 1'b0);
        m.stopBus();
        check("no write started", writeBusy, 1'b0);
        $display("test bad type done");
    endtask

    // 17 bytes mid-page: wraps in page, last one refused
    task automatic testPageFull();
        writeSeq(3'h2, 8'h35, 17, 8'h40);
        openDev(3'h2, 1'b0, 1'b0);
        check("oe while busy", sdaOe, 1'b0);
        m.stopBus();
        check("still busy", writeBusy, 1'b1);
        waitIdle();
        $display("test page full done");
    endtask

    task automatic testBlockSelect();
        writeSeq(3'h5, 8'h30, 1, 8'hC3);
        waitIdle();
        readSeq(3'h2, 8'h30, 16);
        readSeq(3'h5, 8'h30, 1);
        $display("test block select done");
    endtask

    // ********************************************************
    // run control
    // ********************************************************
    task automatic reportAndStop();
        $display("checks %0d mismatches %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    initial begin
        badCount       = 0;
        samplesChecked = 0;
        busyRun        = 16'h0;
        lastRun        = 16'h0;
        sys_rst        = 1'b1;
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge core_clk);
        testReset();
        testBadType();
        testPageFull();
        testBlockSelect();
        reportAndStop();
    end

    // whole run needs about 7400 cycles
    initial begin
        repeat (60000) @(negedge core_clk);
        badCount++;
        reportAndStop();
    end
endmodule
